// ---- hw/mcd_decoder.sv ----
// instruction decoder top: opcode table, byte fetch and machine-cycle sequencing
// Notes on behaviour
// - fetch one, two or three bytes per opcode before completing the instruction.
// - every instruction lasts one, two or four machine cycles, or longer when operand bytes arrive late.
// - a machine cycle is two core clock periods.
// - eight-code groups take working register number from opcode bits 2:0.
// - absolute jump and call target bits 10:8 from opcode top three bits.
// - add: 28-2F register, 25 direct, 26-27 indirect, 24 immediate; one cycle.
// - add with carry: 38-3F, 35, 36-37, 34; one cycle each.
// - subtract with borrow: 98-9F, 95, 96-97, 94; one cycle each.
// - and: 58-5F register; 53 immediate into direct, three bytes two cycles.
// - or: 48-4F register; 43 immediate into direct, three bytes two cycles.
// - exclusive or: 68-6F register; 63 immediate into direct, three bytes two cycles.
// - rotates 23, 33, 03, 13: one byte, one cycle each.
// - code read at accumulator plus pointer 93 or plus PC 83; two cycles.
// - external moves two cycles; E0/F0 pointer address, E2-E3/F2-F3 R0/R1 address.
// - direct to direct move 85: three bytes, two cycles.
// - load pointer 90 three bytes two cycles; increment pointer A3 two cycles.
// - carry with bit 82, B0, 72: two bytes, two cycles.
// - carry to bit 92 two cycles; clear and set bit C2, D2 one cycle.
// - long call 12, absolute call, return 22 and 32: two cycles each.
// - indirect jump 73 to pointer plus accumulator: one byte, two cycles.
// - compare branch B8-BF, B5, B4: three bytes, two cycles.
// - decrement branch D8-DF two bytes, D5 three bytes; two cycles.
// - register selection lies within bank chosen by status word bits 4:3.
// - flag effects per opcode: kept, cleared, set, result-dependent or unknown.
`timescale 1ns/1ps
`default_nettype none
module mcd_decoder #(
  parameter int CLKS_PER_MC = mcd_pkg::CLKS_PER_MC
) (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_sys_rst,
  // program memory byte stream
  input  wire logic               i_code_valid,
  input  wire logic [7:0]         i_code_byte,
  output logic                    o_code_ready,
  // core state
  input  wire logic [7:0]         i_program_status_word,
  // decoded instruction
  output logic                    o_insn_valid,
  output mcd_pkg::mcd_insn_t      o_insn,
  output logic                    o_busy,
  output logic                    o_mc_phase
);

  typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_FETCH, ST_WAIT} mcd_state_t;

  // ************************************************************
  // opcode table
  // ************************************************************
  function automatic mcd_pkg::mcd_info_t mk(input logic [1:0] len, input logic [2:0] cyc,
                                             input mcd_pkg::mcd_class_t cls, input mcd_pkg::mcd_src_t src);
    mcd_pkg::mcd_info_t r;
    r = mcd_pkg::INFO_RST;
    r.len     = len;
    r.mcycles = cyc;
    r.cls     = cls;
    r.src     = src;
    return r;
  endfunction

  function automatic mcd_pkg::mcd_info_t fl(input mcd_pkg::mcd_info_t base, input mcd_pkg::mcd_flag_t c,
                                             input mcd_pkg::mcd_flag_t ov, input mcd_pkg::mcd_flag_t ac);
    mcd_pkg::mcd_info_t r;
    r      = base;
    r.f_c  = c;
    r.f_ov = ov;
    r.f_ac = ac;
    return r;
  endfunction

  function automatic mcd_pkg::mcd_info_t lookup(input logic [7:0] op);
    mcd_pkg::mcd_info_t r;
    mcd_pkg::mcd_info_t a;
    r = mk(2'd1, 3'd1, mcd_pkg::CL_UNSUPPORTED, mcd_pkg::SRC_NONE);
    a = mk(2'd1, 3'd1, mcd_pkg::CL_ARITH, mcd_pkg::SRC_NONE);
    // arithmetic with full flag effect: low nibble selects the source form
    if (op[7:4] == 4'h2 || op[7:4] == 4'h3 || op[7:4] == 4'h9) begin
      if (op[3]) a.src = mcd_pkg::SRC_REG;
      else if (op[3:1] == 3'b011) a.src = mcd_pkg::SRC_INDIRECT;
      else if (op[3:0] == 4'h5) begin
        a.src = mcd_pkg::SRC_DIRECT;
        a.len = 2'd2;
      end else begin
        a.src = mcd_pkg::SRC_IMMEDIATE;
        a.len = 2'd2;
      end
      a = fl(a, mcd_pkg::FLG_RESULT, mcd_pkg::FLG_RESULT, mcd_pkg::FLG_RESULT);
    end
    casez (op)
      // every code ending in 1 is an absolute jump or call; bit 4 tells which
      8'b????0001:  r = mk(2'd2, 3'd2, op[mcd_pkg::CALL_BIT] ? mcd_pkg::CL_CALL : mcd_pkg::CL_JUMP,
                           mcd_pkg::SRC_ABS11);
      8'h00:        r = mk(2'd1, 3'd1, mcd_pkg::CL_NOP, mcd_pkg::SRC_NONE);
      8'h02:        r = mk(2'd3, 3'd2, mcd_pkg::CL_JUMP, mcd_pkg::SRC_IMMEDIATE);
      8'h03, 8'h23: r = mk(2'd1, 3'd1, mcd_pkg::CL_ROTATE, mcd_pkg::SRC_ACC);
      8'h13, 8'h33: r = fl(mk(2'd1, 3'd1, mcd_pkg::CL_ROTATE, mcd_pkg::SRC_ACC),
                           mcd_pkg::FLG_RESULT, mcd_pkg::FLG_KEEP, mcd_pkg::FLG_KEEP);
      8'h04, 8'h14: r = mk(2'd1, 3'd1, mcd_pkg::CL_ARITH, mcd_pkg::SRC_ACC);
      8'h05, 8'h15: r = mk(2'd2, 3'd1, mcd_pkg::CL_ARITH, mcd_pkg::SRC_DIRECT);
      8'b000?011?:  r = mk(2'd1, 3'd1, mcd_pkg::CL_ARITH, mcd_pkg::SRC_INDIRECT);
      8'b000?_1???: r = mk(2'd1, 3'd1, mcd_pkg::CL_ARITH, mcd_pkg::SRC_REG);
      8'h10, 8'h20, 8'h30: r = mk(2'd3, 3'd2, mcd_pkg::CL_JUMP, mcd_pkg::SRC_BIT);
      8'h12:        r = mk(2'd3, 3'd2, mcd_pkg::CL_CALL, mcd_pkg::SRC_IMMEDIATE);
      8'h22, 8'h32: r = mk(2'd1, 3'd2, mcd_pkg::CL_RET, mcd_pkg::SRC_NONE);
      8'b0010_01??, 8'b0010_1???: r = a;
      8'b0011_01??, 8'b0011_1???: r = a;
      8'b1001_01??, 8'b1001_1???: r = a;
      8'h40, 8'h50, 8'h60, 8'h70, 8'h80: r = mk(2'd2, 3'd2, mcd_pkg::CL_JUMP, mcd_pkg::SRC_IMMEDIATE);
      // logic group 4x, 5x, 6x share one layout; 7x is a different family
      8'b010?0010, 8'b01100010: r = mk(2'd2, 3'd1, mcd_pkg::CL_LOGIC, mcd_pkg::SRC_DIRECT);
      8'b010?0011, 8'b01100011: r = mk(2'd3, 3'd2, mcd_pkg::CL_LOGIC,
                                       mcd_pkg::SRC_IMMEDIATE);
      8'b010?0100, 8'b01100100: r = mk(2'd2, 3'd1, mcd_pkg::CL_LOGIC, mcd_pkg::SRC_IMMEDIATE);
      8'b010?0101, 8'b01100101: r = mk(2'd2, 3'd1, mcd_pkg::CL_LOGIC, mcd_pkg::SRC_DIRECT);
      8'b010?011?, 8'b0110011?: r = mk(2'd1, 3'd1, mcd_pkg::CL_LOGIC, mcd_pkg::SRC_INDIRECT);
      8'b010?1???, 8'b01101???: r = mk(2'd1, 3'd1, mcd_pkg::CL_LOGIC, mcd_pkg::SRC_REG);
      8'h72, 8'h82, 8'hA0, 8'hB0: r = fl(mk(2'd2, 3'd2, mcd_pkg::CL_BIT, mcd_pkg::SRC_BIT),
                                         mcd_pkg::FLG_RESULT, mcd_pkg::FLG_KEEP, mcd_pkg::FLG_KEEP);
      8'h73:        r = mk(2'd1, 3'd2, mcd_pkg::CL_JUMP, mcd_pkg::SRC_ACC_PTR);
      8'h74:        r = mk(2'd2, 3'd1, mcd_pkg::CL_MOVE, mcd_pkg::SRC_IMMEDIATE);
      8'h75:        r = mk(2'd3, 3'd2, mcd_pkg::CL_MOVE, mcd_pkg::SRC_IMMEDIATE);
      8'b0111011?:  r = mk(2'd2, 3'd1, mcd_pkg::CL_MOVE, mcd_pkg::SRC_INDIRECT);
      8'b0111_1???: r = mk(2'd2, 3'd1, mcd_pkg::CL_MOVE, mcd_pkg::SRC_REG);
      8'h83:        r = mk(2'd1, 3'd2, mcd_pkg::CL_CODE_READ, mcd_pkg::SRC_ACC_PC);
      8'h93:        r = mk(2'd1, 3'd2, mcd_pkg::CL_CODE_READ, mcd_pkg::SRC_ACC_PTR);
      8'h84, 8'hA4: r = fl(mk(2'd1, 3'd4, mcd_pkg::CL_MULDIV, mcd_pkg::SRC_ACC),
                           mcd_pkg::FLG_CLEAR, mcd_pkg::FLG_RESULT, mcd_pkg::FLG_UNKNOWN);
      8'h85:        r = mk(2'd3, 3'd2, mcd_pkg::CL_MOVE, mcd_pkg::SRC_DIR_DIR);
      8'b1000011?, 8'b1010011?:   r = mk(2'd2, 3'd2, mcd_pkg::CL_MOVE, mcd_pkg::SRC_INDIRECT);
      8'b1000_1???, 8'b1010_1???: r = mk(2'd2, 3'd2, mcd_pkg::CL_MOVE, mcd_pkg::SRC_REG);
      8'h90:        r = mk(2'd3, 3'd2, mcd_pkg::CL_MOVE, mcd_pkg::SRC_PTR16);
      8'hA3:        r = mk(2'd1, 3'd2, mcd_pkg::CL_ARITH, mcd_pkg::SRC_PTR16);
      8'h92:        r = mk(2'd2, 3'd2, mcd_pkg::CL_BIT, mcd_pkg::SRC_BIT);
      8'hA2:        r = fl(mk(2'd2, 3'd1, mcd_pkg::CL_BIT, mcd_pkg::SRC_BIT),
                           mcd_pkg::FLG_RESULT, mcd_pkg::FLG_KEEP, mcd_pkg::FLG_KEEP);
      8'hB2, 8'hC2, 8'hD2: r = mk(2'd2, 3'd1, mcd_pkg::CL_BIT, mcd_pkg::SRC_BIT);
      8'hB3:        r = fl(mk(2'd1, 3'd1, mcd_pkg::CL_BIT, mcd_pkg::SRC_NONE),
                           mcd_pkg::FLG_RESULT, mcd_pkg::FLG_KEEP, mcd_pkg::FLG_KEEP);
      8'hC3:        r = fl(mk(2'd1, 3'd1, mcd_pkg::CL_BIT, mcd_pkg::SRC_NONE),
                           mcd_pkg::FLG_CLEAR, mcd_pkg::FLG_KEEP, mcd_pkg::FLG_KEEP);
      8'hD3:        r = fl(mk(2'd1, 3'd1, mcd_pkg::CL_BIT, mcd_pkg::SRC_NONE),
                           mcd_pkg::FLG_SET, mcd_pkg::FLG_KEEP, mcd_pkg::FLG_KEEP);
      8'hB4:        r = mk(2'd3, 3'd2, mcd_pkg::CL_CMP_BRANCH, mcd_pkg::SRC_IMMEDIATE);
      8'hB5:        r = mk(2'd3, 3'd2, mcd_pkg::CL_CMP_BRANCH, mcd_pkg::SRC_DIRECT);
      8'b1011011?:  r = mk(2'd3, 3'd2, mcd_pkg::CL_CMP_BRANCH, mcd_pkg::SRC_INDIRECT);
      8'b1011_1???: r = mk(2'd3, 3'd2, mcd_pkg::CL_CMP_BRANCH, mcd_pkg::SRC_REG);
      8'hC4, 8'hE4, 8'hF4: r = mk(2'd1, 3'd1, mcd_pkg::CL_LOGIC, mcd_pkg::SRC_ACC);
      8'hD4:        r = fl(mk(2'd1, 3'd1, mcd_pkg::CL_ARITH, mcd_pkg::SRC_ACC),
                           mcd_pkg::FLG_RESULT, mcd_pkg::FLG_UNKNOWN, mcd_pkg::FLG_UNKNOWN);
      8'hD5:        r = mk(2'd3, 3'd2, mcd_pkg::CL_DEC_BRANCH, mcd_pkg::SRC_DIRECT);
      8'b1101_1???: r = mk(2'd2, 3'd2, mcd_pkg::CL_DEC_BRANCH, mcd_pkg::SRC_REG);
      8'hE0, 8'hF0: r = mk(2'd1, 3'd2, mcd_pkg::CL_XDATA, mcd_pkg::SRC_PTR16);
      8'b111?_001?: r = mk(2'd1, 3'd2, mcd_pkg::CL_XDATA, mcd_pkg::SRC_INDIRECT);
      8'hE5, 8'hF5: r = mk(2'd2, 3'd1, mcd_pkg::CL_MOVE, mcd_pkg::SRC_DIRECT);
      8'b111?011?:  r = mk(2'd1, 3'd1, mcd_pkg::CL_MOVE, mcd_pkg::SRC_INDIRECT);
      8'b111?_1???: r = mk(2'd1, 3'd1, mcd_pkg::CL_MOVE, mcd_pkg::SRC_REG);
      default:      r = mk(2'd1, 3'd1, mcd_pkg::CL_UNSUPPORTED, mcd_pkg::SRC_NONE);
    endcase
    r.xdata_write = (r.cls == mcd_pkg::CL_XDATA) && op[4];
    return r;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  mcd_state_t         state;
  mcd_state_t         next_state;
  mcd_pkg::mcd_info_t info;
  mcd_pkg::mcd_info_t next_info;
  logic [7:0]         opcode;
  logic [7:0]         next_opcode;
  logic [7:0]         byte2;
  logic [7:0]         next_byte2;
  logic [7:0]         byte3;
  logic [7:0]         next_byte3;
  logic [1:0]         bank;
  logic [1:0]         next_bank;
  logic [1:0]         byte_cnt;
  logic [1:0]         next_byte_cnt;
  logic               next_code_ready;
  logic               next_insn_valid;
  logic               take;
  logic               timer_start;
  logic               timer_expired;
  logic               timer_phase;

  assign take        = i_code_valid && o_code_ready;
  assign timer_start = (state == ST_LOOKUP);

  always_comb begin
    next_state      = state;
    next_info       = info;
    next_opcode     = opcode;
    next_byte2      = byte2;
    next_byte3      = byte3;
    next_bank       = bank;
    next_byte_cnt   = byte_cnt;
    next_insn_valid = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          next_opcode   = i_code_byte;
          next_info     = lookup(i_code_byte);
          next_bank     = i_program_status_word[mcd_pkg::STATUS_BANK_HI:mcd_pkg::STATUS_BANK_LO];
          next_byte_cnt = mcd_pkg::BYTE_CNT_1;
          next_byte2    = mcd_pkg::BYTE_RST;
          next_byte3    = mcd_pkg::BYTE_RST;
          next_state    = ST_LOOKUP;
        end
      end
      ST_LOOKUP: begin
        next_state = (info.len > byte_cnt) ? ST_FETCH : ST_WAIT;
      end
      ST_FETCH: begin
        if (take) begin
          if (byte_cnt == mcd_pkg::BYTE_CNT_1) begin
            next_byte2 = i_code_byte;
          end else begin
            next_byte3 = i_code_byte;
          end
          next_byte_cnt = byte_cnt + 2'd1;
          if (byte_cnt + 2'd1 == info.len) begin
            next_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // late operand bytes stretch the instruction; a short one never ends early
        if (timer_expired) begin
          next_insn_valid = 1'b1;
          next_state      = ST_IDLE;
        end
      end
    endcase
    next_code_ready = (next_state == ST_IDLE) || (next_state == ST_FETCH);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state        <= ST_IDLE;
      info         <= mcd_pkg::INFO_RST;
      opcode       <= mcd_pkg::BYTE_RST;
      byte2        <= mcd_pkg::BYTE_RST;
      byte3        <= mcd_pkg::BYTE_RST;
      bank         <= mcd_pkg::BANK_RST;
      byte_cnt     <= mcd_pkg::BYTE_CNT_1;
      o_code_ready <= 1'b0;
      o_insn_valid <= 1'b0;
      o_busy       <= 1'b0;
      o_mc_phase   <= 1'b0;
    end else begin
      state        <= next_state;
      info         <= next_info;
      opcode       <= next_opcode;
      byte2        <= next_byte2;
      byte3        <= next_byte3;
      bank         <= next_bank;
      byte_cnt     <= next_byte_cnt;
      o_code_ready <= next_code_ready;
      o_insn_valid <= next_insn_valid;
      o_busy       <= (next_state != ST_IDLE);
      o_mc_phase   <= timer_phase;
    end
  end

  // ************************************************************
  // submodules
  // ************************************************************
  mcd_cycle_timer #(
    .CLKS_PER_MC (CLKS_PER_MC)
  ) u_timer (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (timer_start),
    .i_mcycles (info.mcycles),
    .o_expired (timer_expired),
    .o_phase   (timer_phase)
  );

  // output word loads with the completion pulse, so it holds until the next one
  mcd_operand_fmt u_fmt (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_load    (next_insn_valid),
    .i_opcode  (opcode),
    .i_byte2   (byte2),
    .i_byte3   (byte3),
    .i_bank    (bank),
    .i_info    (info),
    .o_insn    (o_insn)
  );
endmodule
`default_nettype wire

// ---- shared/mcd_pkg.sv ----
// package: shared constants and types of the instruction decoder
package mcd_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLKS_PER_MC   = 2;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int STATUS_BANK_LO = 3;
  localparam int STATUS_BANK_HI = 4;
  localparam int REG_NUM_HI   = 2;
  localparam int ABS_HI_LO    = 5;
  localparam int ABS_HI_TOP   = 7;
  localparam int CALL_BIT     = 4;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam logic [1:0] BANK_RST    = 2'h0;
  localparam logic [1:0] BYTE_CNT_1  = 2'h1;
  localparam logic [1:0] BYTE_CNT_2  = 2'h2;
  localparam logic [1:0] IND_PAD     = 2'h0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    CL_NOP, CL_ARITH, CL_LOGIC, CL_ROTATE, CL_MOVE, CL_CODE_READ, CL_XDATA,
    CL_BIT, CL_JUMP, CL_CALL, CL_RET, CL_CMP_BRANCH, CL_DEC_BRANCH, CL_MULDIV, CL_UNSUPPORTED
  } mcd_class_t;

  typedef enum logic [3:0] {
    SRC_NONE, SRC_REG, SRC_DIRECT, SRC_INDIRECT, SRC_IMMEDIATE, SRC_BIT,
    SRC_ABS11, SRC_PTR16, SRC_ACC_PTR, SRC_ACC_PC, SRC_DIR_DIR, SRC_ACC
  } mcd_src_t;

  typedef enum logic [2:0] {
    FLG_KEEP, FLG_CLEAR, FLG_SET, FLG_RESULT, FLG_UNKNOWN
  } mcd_flag_t;

  typedef struct packed {
    logic [1:0] len;
    logic [2:0] mcycles;
    mcd_class_t cls;
    mcd_src_t   src;
    logic       xdata_write;
    mcd_flag_t  f_c;
    mcd_flag_t  f_ov;
    mcd_flag_t  f_ac;
  } mcd_info_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  byte2;
    logic [7:0]  byte3;
    mcd_info_t   info;
    logic [4:0]  reg_addr;
    logic [10:0] abs_target;
  } mcd_insn_t;

  localparam mcd_info_t INFO_RST = '{2'd1, 3'd1, CL_NOP, SRC_NONE, 1'b0, FLG_KEEP, FLG_KEEP, FLG_KEEP};

endpackage

// ---- hw/mcd_cycle_timer.sv ----
// machine-cycle timer: counts core clocks into machine cycles
`timescale 1ns/1ps
`default_nettype none
module mcd_cycle_timer #(
  parameter int CLKS_PER_MC = mcd_pkg::CLKS_PER_MC
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // control
  input  wire logic       i_start,
  input  wire logic [2:0] i_mcycles,
  // status
  output logic            o_expired,
  output logic            o_phase
);
  localparam int CW = (CLKS_PER_MC > 1) ? $clog2(CLKS_PER_MC) : 1;
  localparam logic [CW-1:0] CLK_LAST = CW'(CLKS_PER_MC - 1);

  logic [CW-1:0] clk_cnt;
  logic [CW-1:0] next_clk_cnt;
  logic [2:0]    mc_cnt;
  logic [2:0]    next_mc_cnt;
  logic [2:0]    target;
  logic [2:0]    next_target;
  logic          run;
  logic          next_run;
  logic          next_expired;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_clk_cnt = clk_cnt;
    next_mc_cnt  = mc_cnt;
    next_target  = target;
    next_run     = run;
    next_expired = o_expired;
    if (i_start) begin
      next_clk_cnt = '0;
      next_mc_cnt  = '0;
      next_target  = i_mcycles;
      next_run     = 1'b1;
      next_expired = 1'b0;
    end else if (run) begin
      if (clk_cnt == CLK_LAST) begin
        next_clk_cnt = '0;
        next_mc_cnt  = mc_cnt + 3'd1;
        if (mc_cnt + 3'd1 == target) begin
          next_run     = 1'b0;
          next_expired = 1'b1;
        end
      end else begin
        next_clk_cnt = clk_cnt + CW'(1);
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      clk_cnt   <= '0;
      mc_cnt    <= '0;
      target    <= '0;
      run       <= 1'b0;
      o_expired <= 1'b0;
      o_phase   <= 1'b0;
    end else begin
      clk_cnt   <= next_clk_cnt;
      mc_cnt    <= next_mc_cnt;
      target    <= next_target;
      run       <= next_run;
      o_expired <= next_expired;
      o_phase   <= next_clk_cnt[0];
    end
  end
endmodule
`default_nettype wire

// ---- hw/mcd_operand_fmt.sv ----
// operand formatter: builds the registered decoded-instruction word
`timescale 1ns/1ps
`default_nettype none
module mcd_operand_fmt (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // fields
  input  wire logic              i_load,
  input  wire logic [7:0]        i_opcode,
  input  wire logic [7:0]        i_byte2,
  input  wire logic [7:0]        i_byte3,
  input  wire logic [1:0]        i_bank,
  input  wire mcd_pkg::mcd_info_t i_info,
  // result
  output mcd_pkg::mcd_insn_t     o_insn
);
  mcd_pkg::mcd_insn_t next_insn;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_insn = o_insn;
    if (i_load) begin
      next_insn.opcode     = i_opcode;
      next_insn.byte2      = i_byte2;
      next_insn.byte3      = i_byte3;
      next_insn.info       = i_info;
      // bank picks one of four groups of eight working registers
      if (i_info.src == mcd_pkg::SRC_INDIRECT || i_info.xdata_write && i_info.src == mcd_pkg::SRC_INDIRECT) begin
        next_insn.reg_addr = {i_bank, mcd_pkg::IND_PAD, i_opcode[0]};
      end else begin
        next_insn.reg_addr = {i_bank, i_opcode[mcd_pkg::REG_NUM_HI:0]};
      end
      next_insn.abs_target = {i_opcode[mcd_pkg::ABS_HI_TOP:mcd_pkg::ABS_HI_LO], i_byte2};
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_insn <= '{mcd_pkg::BYTE_RST, mcd_pkg::BYTE_RST, mcd_pkg::BYTE_RST, mcd_pkg::INFO_RST, 5'h00, 11'h000};
    end else begin
      o_insn <= next_insn;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/mcd_decoder_props.sv ----
// checker: port-level timing and decode properties of the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module mcd_decoder_props #(
  parameter int CLKS_PER_MC = 2
) (
  // clock and reset
  input wire logic               i_clk,
  input wire logic               i_sys_rst,
  // byte stream and core state
  input wire logic               i_code_valid,
  input wire logic [7:0]         i_code_byte,
  input wire logic               o_code_ready,
  input wire logic [7:0]         i_program_status_word,
  // decoded instruction
  input wire logic               o_insn_valid,
  input wire mcd_pkg::mcd_insn_t o_insn,
  input wire logic               o_busy,
  input wire logic               o_mc_phase
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_pulse; o_insn_valid |=> !o_insn_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("done pulse wider than one cycle");
  property p_len; o_insn_valid |-> o_insn.info.len inside {2'h1, 2'h2, 2'h3}; endproperty
  a_len: assert property (p_len) else $error("length outside one to three");
  property p_mcyc; o_insn_valid |-> o_insn.info.mcycles inside {3'h1, 3'h2, 3'h4}; endproperty
  a_mcyc: assert property (p_mcyc) else $error("cycle count outside one, two, four");
  // a one-cycle op still spends two clocks per machine cycle plus lookup
  property p_minlat; $rose(o_busy) |-> !o_insn_valid [*3]; endproperty
  a_minlat: assert property (p_minlat) else $error("instruction done too early");
  property p_reg;
    o_insn_valid && o_insn.info.src == mcd_pkg::SRC_REG |-> o_insn.reg_addr[2:0] == o_insn.opcode[2:0];
  endproperty
  a_reg: assert property (p_reg) else $error("register number not from opcode");
  property p_abs;
    o_insn_valid && o_insn.info.src == mcd_pkg::SRC_ABS11
      |-> o_insn.abs_target == {o_insn.opcode[7:5], o_insn.byte2};
  endproperty
  a_abs: assert property (p_abs) else $error("absolute target wrong");
  property p_add;
    o_insn_valid && o_insn.opcode[7:3] == 5'h05 |-> o_insn.info.mcycles == 3'h1 && o_insn.info.len == 2'h1;
  endproperty
  a_add: assert property (p_add) else $error("register add not one byte one cycle");
  property p_muldiv;
    o_insn_valid && o_insn.info.mcycles == 3'h4
      |-> (o_insn.opcode == 8'hA4 || o_insn.opcode == 8'h84) && o_insn.info.len == 2'h1;
  endproperty
  a_muldiv: assert property (p_muldiv) else $error("four-cycle op not multiply or divide");
endmodule
bind mcd_decoder mcd_decoder_props #(.CLKS_PER_MC(CLKS_PER_MC)) mcd_decoder_props_inst (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_code_valid(i_code_valid), .i_code_byte(i_code_byte),
  .o_code_ready(o_code_ready), .i_program_status_word(i_program_status_word),
  .o_insn_valid(o_insn_valid), .o_insn(o_insn), .o_busy(o_busy), .o_mc_phase(o_mc_phase));
`default_nettype wire

// ---- testbench/mcd_prog_mem.sv ----
// partner: program memory handing instruction bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module mcd_prog_mem (
  // clock and handshake
  input  wire logic  i_clk,
  input  wire logic  i_ready,
  input  wire logic  i_slow,
  // byte stream
  output logic       o_valid,
  output logic [7:0] o_byte
);
  logic [7:0] q[$];
  int         gap;
  initial begin
    o_valid = 1'b0;
    o_byte  = 8'h00;
    gap     = 0;
  end
  // slow mode idles after every taken byte; idle bus toggles, never stale
  always @(posedge i_clk) begin
    if (o_valid && i_ready) begin
      void'(q.pop_front());
      gap = i_slow ? 3 : 0;
    end
    // new byte shows on the falling edge, well clear of the taking edge
    @(negedge i_clk);
    if (gap > 0) gap--;
    o_valid = (q.size() > 0) && (gap == 0);
    o_byte  = o_valid ? q[0] : ~o_byte;
  end
endmodule
`default_nettype wire

// ---- testbench/mcd_decoder_tb.sv ----
// testbench: self-checking bench of the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module mcd_decoder_tb;
  logic               clk, rst, slow, cv, cr, iv, busy, ph;
  logic [7:0]         cb, program_status_word;
  mcd_pkg::mcd_insn_t insn;
  int                 errors, checked, n;
  mcd_decoder #(.CLKS_PER_MC(2)) mcd_decoder_inst (.i_clk(clk), .i_sys_rst(rst), .i_code_valid(cv),
    .i_code_byte(cb), .o_code_ready(cr), .i_program_status_word(program_status_word), .o_insn_valid(iv),
    .o_insn(insn), .o_busy(busy), .o_mc_phase(ph));
  mcd_prog_mem mcd_prog_mem_inst (.i_clk(clk), .i_ready(cr), .i_slow(slow), .o_valid(cv), .o_byte(cb));
  always #4 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one instruction; latency counted in edges from the opcode edge
  task automatic exec(input logic [7:0] op, input logic [7:0] b2, input int len, input int mc);
    int         k;
    logic [1:0] ph23;
    @(posedge clk);
    mcd_prog_mem_inst.q.push_back(op);
    if (len > 1) mcd_prog_mem_inst.q.push_back(b2);
    if (len > 2) mcd_prog_mem_inst.q.push_back(8'h5A);
    // busy rises just after the edge that takes the opcode
    k = 0;
    do begin @(posedge clk); #1; k++; end while (!busy && k < 60);
    n = 0;
    ph23 = 2'h0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n == 2) ph23[1] = ph;
      if (n == 3) ph23[0] = ph;
    end while (!iv && n < 60);
    check(16'(iv), 16'h0001);
    check(16'({busy, cr}), 16'h0001);
    check(16'(ph23), 16'h0001);
    check(16'(insn.opcode), 16'(op));
    check(16'(insn.info.len), 16'(len));
    check(16'(insn.info.mcycles), 16'(mc));
    if (len > 1) check(16'(insn.byte2), 16'(b2));
    if (len > 2) check(16'(insn.byte3), 16'h005A);
    if (!slow) check(16'(n), 16'(2 * mc + 2));
  endtask
  // table entries: opcode, bytes, machine cycles
  task automatic t_alu;
    logic [15:0] tb[16] = '{16'h2811, 16'h2521, 16'h2611, 16'h2421, 16'h3811, 16'h3521, 16'h3611, 16'h3421,
      16'h9811, 16'h9521, 16'h9611, 16'h9421, 16'h2311, 16'h3311, 16'h0311, 16'h1311};
    foreach (tb[i]) exec(tb[i][15:8], 8'h3C, tb[i][7:4], tb[i][3:0]);
  endtask
  task automatic t_logic;
    logic [15:0] tb[9] = '{16'h5811, 16'h5332, 16'h4811, 16'h4332, 16'h6811, 16'h6332, 16'h8532, 16'h9032,
      16'hA312};
    foreach (tb[i]) exec(tb[i][15:8], 8'hC3, tb[i][7:4], tb[i][3:0]);
  endtask
  task automatic t_ctl;
    logic [15:0] tb[23] = '{16'h9312, 16'h8312, 16'hE012, 16'hF012, 16'hE212, 16'hF312, 16'h8222, 16'hB022,
      16'h7222, 16'h9222, 16'hC221, 16'hD221, 16'h1232, 16'h2212, 16'h3212, 16'h7312, 16'hB832, 16'hB532,
      16'hB432, 16'hD822, 16'hD532, 16'hA414, 16'h8414};
    foreach (tb[i]) exec(tb[i][15:8], 8'h96, tb[i][7:4], tb[i][3:0]);
  endtask
  // bank from status word, slow memory on odd passes
  task automatic t_reg;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      slow = i[0];
      program_status_word = {3'h5, 2'(i % 4), 3'h2};
      exec(8'hD8 + 8'(i), 8'h0F, 2, 2);
      check(16'(insn.reg_addr), 16'({2'(i % 4), 3'(i)}));
    end
    slow = 1'b0;
  endtask
  task automatic t_abs;
    logic [7:0] ops[4] = '{8'h11, 8'hF1, 8'h01, 8'hE1};
    foreach (ops[i]) begin
      exec(ops[i], 8'hA5 ^ 8'(i), 2, 2);
      check(16'(insn.abs_target), 16'({ops[i][7:5], 8'hA5 ^ 8'(i)}));
    end
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    slow = 1'b0;
    program_status_word = 8'h00;
    errors = 0;
    checked = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_alu();
    t_logic();
    t_ctl();
    t_reg();
    t_abs();
    complete_run();
  end
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
